// *** dual_gpio_control_tb_top.sv ***
// bench for the two-pin control block: register port tasks and pin scenarios
// assumes gpc_board_model closes the pin loop
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module dual_gpio_control_tb_top;
  import gpc_pkg::*;
  logic ref_clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, ev_clear = 0, int_mask = 0;
  gpc_addr_t cfg_addr = 8'h00;
  gpc_be_t cfg_be = 4'h0;
  gpc_word_t cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  gpc_pair_t pin_i, board_lvl = 2'h0;
  logic [1:0] pin_o, pin_oe;
  logic gp_event_pulse, gp_event_status, gp_irq;
  int fails = 0, n_tests = 0, cyc = 0, n_ev = 0;
  gpc_dual_gpio dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .ev_clear(ev_clear), .int_mask(int_mask), .gp_event_pulse(gp_event_pulse),
    .gp_event_status(gp_event_status), .gp_irq(gp_irq));
  gpc_board_model board_u (.pin_o(pin_o), .pin_oe(pin_oe), .board_lvl(board_lvl),
    .pin_i(pin_i));
  always #5 ref_clk = ~ref_clk;
  // cycle count for the hang limit, event pulse count
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (gp_event_pulse === 1'b1) n_ev <= n_ev + 1;
    if (cyc == 2000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // one write strobe, held across its taking edge
  task automatic wr(input gpc_addr_t a, input gpc_be_t be, input gpc_word_t d);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1;
    @(posedge ref_clk) #1;
    cfg_wr = 0;
  endtask : wr
  // one read strobe, data checked in the following cycle
  task automatic rd(input gpc_addr_t a, input gpc_word_t ex);
    cfg_addr = a;
    cfg_rd = 1;
    @(posedge ref_clk) #1;
    cfg_rd = 0;
    `CHK("cfg_rdata", ex, cfg_rdata)
  endtask : rd
  // board flips one pin, then events are counted over six cycles
  task automatic flip(input int k, input int ex);
    n_ev = 0;
    board_lvl[k] = ~board_lvl[k];
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("event count", ex, n_ev)
  endtask : flip
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1;
    @(posedge ref_clk) #1;
    rd(8'hfc, 32'h0000_0000);
    wr(8'hfc, 4'hf, 32'hffff_ffff);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("pin_oe", 2'h3, pin_oe)
    `CHK("pin_o", 2'h0, pin_o)
    wr(8'hf8, 4'hf, 32'hffff_ffff);
    rd(8'hf8, 32'h0000_0000);
    rd(8'hfc, 32'hb1b1_0000);
    wr(8'hfc, 4'hf, 32'h0000_0000);
    `CHK("pin_oe off", 2'h0, pin_oe)
    flip(1, 0);
    rd(8'hfc, 32'h0100_0000);
    wr(8'hfc, 4'h4, 32'hff80_0000);
    flip(0, 1);
    flip(1, 0);
    rd(8'hfc, 32'h0081_0000);
    wr(8'hfc, 4'h8, 32'h8000_0000);
    flip(1, 1);
    `CHK("status", 1'b1, gp_event_status)
    int_mask = 1;
    #1;
    `CHK("irq on", 1'b1, gp_irq)
    int_mask = 0;
    #1;
    `CHK("irq masked", 1'b0, gp_irq)
    ev_clear = 1;
    @(posedge ref_clk) #1;
    ev_clear = 0;
    @(posedge ref_clk) #1;
    `CHK("status clear", 1'b0, gp_event_status)
    wr(8'hfc, 4'hc, 32'h1100_0000);
    `CHK("pin_o drive", 2'h2, pin_o)
    `CHK("pin_oe upper", 2'h2, pin_oe)
    print_verdict();
  end
endmodule : dual_gpio_control_tb_top
`default_nettype wire

// *** gpc_board_model.sv ***
// board-side model of the two general-purpose pins
// assumes pin_oe high means the block drives the wire
`timescale 1ns/1ps
`default_nettype none
module gpc_board_model (
  input wire logic [1:0] pin_o, // block drive levels
  input wire logic [1:0] pin_oe, // block output enables
  input wire logic [1:0] board_lvl, // level the board drives when released
  output logic [1:0] pin_i // resolved wire level
);
  // each wire follows the block when enabled, else the board
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & board_lvl);
endmodule : gpc_board_model
`default_nettype wire

// *** gpc_consts.svh ***
// constants for the two-pin general-purpose control register
// assumes inclusion by bare name from the design files
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
`define GPC_CTRL_OFFSET 8'hfc
`define GPC_CTRL_RESET 32'h0000_0000
`define GPC_RSVD_MASK 32'h4e4e_ffff
`define GPC_BIT_UP_EVEN 31
`define GPC_BIT_UP_INV 29
`define GPC_BIT_UP_OE 28
`define GPC_BIT_UP_VAL 24
`define GPC_BIT_LO_EVEN 23
`define GPC_BIT_LO_INV 21
`define GPC_BIT_LO_OE 20
`define GPC_BIT_LO_VAL 16
`define GPC_BE_UPPER 3
`define GPC_BE_LOWER 2
`define GPC_PIN_UPPER 1
`define GPC_PIN_LOWER 0
`define GPC_PAIR_RESET 2'h0
`define GPC_SYNC_LAT 2
`define GPC_PREV_LAT 3
`endif

// *** gpc_dual_gpio.sv ***
// two general-purpose pins controlled by one configuration register
// assumes a configuration-space access port clocked by ref_clk; pins are asynchronous
// Behaviour
// - all pin controls in one register at FCh
// - upper enable bit 31: event on level change
// - lower enable bit 23: event on level change
// - event recorded as status, mask gates interrupt
// - invert bits 29/21 invert pin polarity
// - output enable bits 28/20 drive, else high-z
// - data bits 24/16 read current pin value
// - data write stores value, driven when enabled
// - reserved bits ignore writes, read zero
`include "gpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module gpc_dual_gpio (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire gpc_pkg::gpc_addr_t cfg_addr, // configuration byte offset
  input wire logic cfg_wr, // configuration write strobe
  input wire logic cfg_rd, // configuration read strobe
  input wire gpc_pkg::gpc_be_t cfg_be, // write byte enables
  input wire gpc_pkg::gpc_word_t cfg_wdata, // write data
  output logic [31:0] cfg_rdata, // read data, valid cycle after cfg_rd
  input wire gpc_pkg::gpc_pair_t pin_i, // pin input levels
  output logic [1:0] pin_o, // pin drive levels
  output logic [1:0] pin_oe, // pin output enables
  input wire logic ev_clear, // clear of the event status bit
  input wire logic int_mask, // mask bit for the event
  output logic gp_event_pulse, // one-cycle pin change event
  output logic gp_event_status, // sticky event status
  output logic gp_irq // masked interrupt request
);
  import gpc_pkg::*;

  gpc_pair_t ev_en_ff, inv_ff, oe_ff, val_ff, drive_ff;
  gpc_pair_t meta_ff, sync_ff, prev_ff;
  gpc_word_t rdata_ff;
  logic status_ff;

  // address decode and next control values per byte lane
  wire hit = (cfg_addr == `GPC_CTRL_OFFSET);
  wire wr_hit = cfg_wr && hit;
  wire we_up = wr_hit && cfg_be[`GPC_BE_UPPER];
  wire we_lo = wr_hit && cfg_be[`GPC_BE_LOWER];
  wire gpc_pair_t nxt_ev_en = {we_up ? cfg_wdata[`GPC_BIT_UP_EVEN] : ev_en_ff[`GPC_PIN_UPPER],
                               we_lo ? cfg_wdata[`GPC_BIT_LO_EVEN] : ev_en_ff[`GPC_PIN_LOWER]};
  wire gpc_pair_t nxt_inv = {we_up ? cfg_wdata[`GPC_BIT_UP_INV] : inv_ff[`GPC_PIN_UPPER],
                             we_lo ? cfg_wdata[`GPC_BIT_LO_INV] : inv_ff[`GPC_PIN_LOWER]};
  wire gpc_pair_t nxt_oe = {we_up ? cfg_wdata[`GPC_BIT_UP_OE] : oe_ff[`GPC_PIN_UPPER],
                            we_lo ? cfg_wdata[`GPC_BIT_LO_OE] : oe_ff[`GPC_PIN_LOWER]};
  wire gpc_pair_t nxt_val = {we_up ? cfg_wdata[`GPC_BIT_UP_VAL] : val_ff[`GPC_PIN_UPPER],
                             we_lo ? cfg_wdata[`GPC_BIT_LO_VAL] : val_ff[`GPC_PIN_LOWER]};
  wire gpc_pair_t nxt_drive = nxt_val ^ nxt_inv;

  // control bits; reserved positions have no storage at all
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_en_ff <= `GPC_PAIR_RESET;
      inv_ff <= `GPC_PAIR_RESET;
      oe_ff <= `GPC_PAIR_RESET;
      val_ff <= `GPC_PAIR_RESET;
      drive_ff <= `GPC_PAIR_RESET;
    end else begin
      ev_en_ff <= nxt_ev_en;
      inv_ff <= nxt_inv;
      oe_ff <= nxt_oe;
      val_ff <= nxt_val;
      drive_ff <= nxt_drive;
    end
  end

  // pin drivers
  assign pin_o = drive_ff;
  assign pin_oe = oe_ff;

  // two-stage synchroniser then previous sample for change detect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= `GPC_PAIR_RESET;
      sync_ff <= `GPC_PAIR_RESET;
      prev_ff <= `GPC_PAIR_RESET;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // change on raw level so toggling invert makes no event
  wire gpc_pair_t changed = sync_ff ^ prev_ff;
  wire gpc_pair_t logical_in = sync_ff ^ inv_ff;
  assign gp_event_pulse = |(changed & ev_en_ff);

  // sticky status, a new event wins over a clear
  wire nxt_status = gp_event_pulse || (status_ff && !ev_clear);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
    end
  end
  assign gp_event_status = status_ff;
  assign gp_irq = status_ff && int_mask;

  // read image: reserved bits zero, unmapped offsets read zero
  wire gpc_word_t ctrl_image = {ev_en_ff[`GPC_PIN_UPPER], 1'b0, inv_ff[`GPC_PIN_UPPER],
                                oe_ff[`GPC_PIN_UPPER], 3'h0, logical_in[`GPC_PIN_UPPER],
                                ev_en_ff[`GPC_PIN_LOWER], 1'b0, inv_ff[`GPC_PIN_LOWER],
                                oe_ff[`GPC_PIN_LOWER], 3'h0, logical_in[`GPC_PIN_LOWER],
                                16'h0000};
  wire gpc_word_t nxt_rdata = (cfg_rd && hit) ? ctrl_image : `GPC_CTRL_RESET;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `GPC_CTRL_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign cfg_rdata = rdata_ff;

  // checks: read image
  a_rsvd_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_rdata & `GPC_RSVD_MASK) == `GPC_CTRL_RESET)
    else $error("reserved bits read nonzero");

  a_unmapped_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_rd && !hit) |=> (cfg_rdata == `GPC_CTRL_RESET))
    else $error("unmapped offset read nonzero");

  // read data stands one cycle only, zero between reads
  a_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cfg_rd |=> (cfg_rdata == `GPC_CTRL_RESET))
    else $error("read data not zero when idle");

  // writes elsewhere leave the pins alone
  a_other_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_wr && !hit) |=> ($stable(pin_oe) && $stable(pin_o)))
    else $error("write to other offset changed pins");

  // checks: change events after the synchroniser delay
  a_upper_change_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(pin_i[`GPC_PIN_UPPER], `GPC_SYNC_LAT) != $past(pin_i[`GPC_PIN_UPPER], `GPC_PREV_LAT)
      && ev_en_ff[`GPC_PIN_UPPER] && $past(rst_n, `GPC_PREV_LAT))
      |-> gp_event_pulse)
    else $error("upper pin change gave no event");

  a_lower_change_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(pin_i[`GPC_PIN_LOWER], `GPC_SYNC_LAT) != $past(pin_i[`GPC_PIN_LOWER], `GPC_PREV_LAT)
      && ev_en_ff[`GPC_PIN_LOWER] && $past(rst_n, `GPC_PREV_LAT))
      |-> gp_event_pulse)
    else $error("lower pin change gave no event");

  // no enabled pin, no event
  a_no_event_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ev_en_ff == `GPC_PAIR_RESET) |-> !gp_event_pulse)
    else $error("event raised with both enables clear");

  sequence s_event_seen;
    gp_event_pulse ##1 gp_event_status;
  endsequence
  a_event_masked_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gp_event_pulse && int_mask) |-> s_event_seen ##0 (gp_irq || !int_mask))
    else $error("event not recorded or not raised");

  // a new event wins over a clear in the same cycle
  a_status_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gp_event_pulse |=> gp_event_status)
    else $error("event lost against clear");

  a_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ev_clear && !gp_event_pulse) |=> !gp_event_status)
    else $error("status not cleared");

  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!int_mask || !gp_event_status) |-> !gp_irq)
    else $error("interrupt raised while masked or idle");

  // checks: writes reach the pin controls
  a_upper_oe_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && cfg_be[`GPC_BE_UPPER]) |=>
      (pin_oe[`GPC_PIN_UPPER] == $past(cfg_wdata[`GPC_BIT_UP_OE])))
    else $error("upper output enable not taken");

  a_lower_oe_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && cfg_be[`GPC_BE_LOWER]) |=>
      (pin_oe[`GPC_PIN_LOWER] == $past(cfg_wdata[`GPC_BIT_LO_OE])))
    else $error("lower output enable not taken");

  a_lower_drive_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && cfg_be[`GPC_BE_LOWER]) |=> (pin_o[`GPC_PIN_LOWER] ==
      ($past(cfg_wdata[`GPC_BIT_LO_VAL]) ^ $past(cfg_wdata[`GPC_BIT_LO_INV]))))
    else $error("lower drive value wrong after write");

  a_upper_drive_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && cfg_be[`GPC_BE_UPPER]) |=> (pin_o[`GPC_PIN_UPPER] ==
      ($past(cfg_wdata[`GPC_BIT_UP_VAL]) ^ $past(cfg_wdata[`GPC_BIT_UP_INV]))))
    else $error("upper drive value wrong after write");

  // no byte enable, no change to the pin controls
  a_no_lane_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && !cfg_be[`GPC_BE_UPPER] && !cfg_be[`GPC_BE_LOWER]) |=>
      ($stable(pin_oe) && $stable(pin_o)))
    else $error("write without lane changed pins");

  // checks: data bits read the synchronised pin level
  a_upper_read_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_rd && hit && $past(rst_n, `GPC_PREV_LAT)) |=>
      (cfg_rdata[`GPC_BIT_UP_VAL] == ($past(pin_i[`GPC_PIN_UPPER], `GPC_PREV_LAT)
        ^ $past(inv_ff[`GPC_PIN_UPPER]))))
    else $error("upper data read not pin level");

  a_lower_read_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_rd && hit && $past(rst_n, `GPC_PREV_LAT)) |=>
      (cfg_rdata[`GPC_BIT_LO_VAL] == ($past(pin_i[`GPC_PIN_LOWER], `GPC_PREV_LAT)
        ^ $past(inv_ff[`GPC_PIN_LOWER]))))
    else $error("lower data read not pin level");

  // one pin change gives one pulse, never two in a row
  a_single_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gp_event_pulse && $past(pin_i) == $past(pin_i, `GPC_SYNC_LAT)) |=> !gp_event_pulse)
    else $error("one pin change gave two events");
endmodule : gpc_dual_gpio
`default_nettype wire

// *** gpc_pkg.sv ***
// types shared by the general-purpose pin control block
// assumes gpc_consts.svh holds the numeric constants
`default_nettype none
package gpc_pkg;
  typedef logic [31:0] gpc_word_t; // configuration data word
  typedef logic [7:0] gpc_addr_t; // configuration byte offset
  typedef logic [3:0] gpc_be_t; // byte enables
  typedef logic [1:0] gpc_pair_t; // one bit per pin, upper at index 1
endpackage : gpc_pkg
`default_nettype wire
